// file: shared/csr_irq_defines.svh
/*
  Register offsets, field positions and reset values of the bridge CSR block.
  Assumes byte addresses of a 16 KB space, one 32-bit word per register.
*/
`ifndef CSR_IRQ_DEFINES_SVH
`define CSR_IRQ_DEFINES_SVH
// ==========================================================================
// Offsets
`define OFS_LINK_STATUS  14'h0040
`define OFS_LINK_ENABLE  14'h0050
`define OFS_FAB_VECTOR   14'h0060
`define OFS_IN_MBOX      14'h0800
`define OFS_OUT_MBOX     14'h0900
`define OFS_FAB_STATUS   14'h3060
`define OFS_FAB_ENABLE   14'h3070
`define OFS_OUT_MBOX_FAB 14'h3A00
`define OFS_IN_MBOX_FAB  14'h3B00
`define MBOX_WIN_MASK    14'h3FE0
`define WORD_MASK        14'h3FFC
// ==========================================================================
// Fields and reset values
`define OUT_FLAG_LSB     16
`define FAB_NONE_VECTOR  5'h10
`define LINK_FLAGS_RST   8'h00
`define LINK_EN_RST      24'h000000
`define FAB_FLAGS_RST    8'h00
`define FAB_EN_RST       8'h00
`define MBOX_RST         32'h00000000
`endif

// file: shared/csr_irq_pkg.sv
/*
  Types and shared helpers of the bridge CSR block.
  Assumes nothing beyond the defines header.
*/
package csr_irq_pkg;
  // ========================================================================
  // Types
  typedef enum logic [1:0] {
    REGION_LINK = 2'h0,
    REGION_XLAT = 2'h1,
    REGION_RP   = 2'h2,
    REGION_FAB  = 2'h3
  } region_t;

  typedef enum logic [1:0] {
    MSI_IDLE = 2'b01,
    MSI_SENT = 2'b10
  } msi_state_t;

  // ========================================================================
  // Byte-lane merge
  function automatic logic [31:0] be_merge(input logic [31:0] old_v,
                                           input logic [31:0] new_v,
                                           input logic [3:0]  be);
    logic [31:0] res;
    res = old_v;
    for (int i = 0; i < 4; i++) begin
      if (be[i]) begin
        res[i*8 +: 8] = new_v[i*8 +: 8];
      end
    end
    return res;
  endfunction : be_merge
endpackage : csr_irq_pkg

// file: shared/mbox_if.sv
/*
  Carrier between the CSR decoder and the mailbox store.
  Assumes one clock; read data is combinational from rd_idx.
*/
`timescale 1ns/1ps
interface mbox_if;
  logic        wr_en;
  logic [3:0]  wr_idx;
  logic [31:0] wr_data;
  logic [3:0]  wr_be;
  logic [3:0]  rd_idx;
  logic [31:0] rd_data;

  modport store (input wr_en, wr_idx, wr_data, wr_be, rd_idx, output rd_data);
  modport user  (output wr_en, wr_idx, wr_data, wr_be, rd_idx, input rd_data);
endinterface : mbox_if

// file: rtl/mbox_bank.sv
/*
  Sixteen mailbox words: index 0-7 inbound, 8-15 outbound.
  Assumes the decoder enforces which side may write which half.
*/
`timescale 1ns/1ps
`include "csr_irq_defines.svh"
module mbox_bank (
  input  wire logic core_clk,
  input  wire logic reset,
  mbox_if.store     mb
);
  logic [31:0] word_r [16];

  // ========================================================================
  // Storage
  always_ff @(posedge core_clk or posedge reset) begin
    if (reset) begin
      for (int i = 0; i < 16; i++) begin
        word_r[i] <= `MBOX_RST;
      end
    end else if (mb.wr_en) begin
      word_r[mb.wr_idx] <= csr_irq_pkg::be_merge(word_r[mb.wr_idx], mb.wr_data, mb.wr_be);
    end
  end

  assign mb.rd_data = word_r[mb.rd_idx];
endmodule : mbox_bank

// file: rtl/pcie_bridge_csr_irq.sv
/*
  Bridge register slave: 16 KB decode, mailboxes, link and fabric interrupts.
  Assumes requests on the same clock; interrupt and mode pins are asynchronous.
*/
`timescale 1ns/1ps
`include "csr_irq_defines.svh"
// Behaviour
// - Registers live in this slave module, reached only through its port.
// - Decode a 16 KB space as four 4 KB regions.
// - No requester restriction; every request reaches every region.
// - Lowest region: link enables, inbound mailbox writes, outbound reads.
// - Second region holds translation tables, passed to the external port.
// - Third region holds root-port request registers, passed externally.
// - Highest region: fabric enables, outbound writes, inbound reads.
// - Undefined addresses read as any value; here zero.
// - Link status at 0x40, link enable 0x50, fabric vector 0x60.
// - Inbound mailboxes from 0x800, outbound mailboxes from 0x900.
// - Fabric status 0x3060, legacy enable 0x3070; meaning depends on port role.
// - Fabric views: inbound at 0x3B00, outbound at 0x3A00.
// - Writing outbound mailbox n sets status bit 16+n; write one clears.
// - Status bits 15..0 show live fabric interrupt levels, read-only.
// - Sixteen fabric interrupt inputs, one status bit each.
// - Link interrupt asserts when any status bit and its enable are set.
// - Link interrupt is sent as MSI or legacy per the mode.
// - Enable bits 23..16 gate outbound mailbox interrupts.
// - Enable bits 15..0 gate fabric interrupt inputs.
// - Link write to inbound mailbox n sets fabric status bit n.
// - Outbound mailboxes are read-only from the link view.
module pcie_bridge_csr_irq (
  input  wire logic        core_clk,
  input  wire logic        reset,
  input  wire logic [13:0] reg_addr,
  input  wire logic        reg_write,
  input  wire logic        reg_read,
  input  wire logic [31:0] reg_wdata,
  input  wire logic [3:0]  reg_byteen,
  output logic [31:0]      reg_rdata,
  output logic             reg_rdvalid,
  input  wire logic [15:0] fabric_irq_in,
  input  wire logic        msi_mode,
  input  wire logic        root_port_mode,
  input  wire logic [3:0]  rp_intx_in,
  output logic             ext_wr,
  output logic             ext_rd,
  output logic [1:0]       ext_region,
  output logic [11:0]      ext_addr,
  output logic [31:0]      ext_wdata,
  output logic [3:0]       ext_byteen,
  input  wire logic [31:0] ext_rdata,
  output logic             link_irq,
  output logic             intx_assert,
  output logic             msi_req,
  output logic             fabric_irq
);
  // ========================================================================
  // Helpers
  function automatic logic hit(input logic [13:0] a, input logic [13:0] base,
                               input logic [13:0] mask);
    return (a & mask) == base;
  endfunction : hit

  function automatic logic [4:0] first_set(input logic [15:0] v);
    logic [4:0] r;
    r = `FAB_NONE_VECTOR;
    for (int i = 15; i >= 0; i--) begin
      if (v[i]) begin
        r = 5'(i);
      end
    end
    return r;
  endfunction : first_set

  // ========================================================================
  // Pin synchronisers
  logic [21:0] meta_r;
  logic [21:0] sync_r;
  logic [15:0] fab_lvl;
  logic        msi_s;
  logic        root_s;
  logic [3:0]  rp_intx_s;

  always_ff @(posedge core_clk or posedge reset) begin
    if (reset) begin
      meta_r <= 22'h000000;
      sync_r <= 22'h000000;
    end else begin
      meta_r <= {rp_intx_in, root_port_mode, msi_mode, fabric_irq_in};
      sync_r <= meta_r;
    end
  end

  assign fab_lvl   = sync_r[15:0];
  assign msi_s     = sync_r[16];
  assign root_s    = sync_r[17];
  assign rp_intx_s = sync_r[21:18];

  // ========================================================================
  // Request decode
  csr_irq_pkg::region_t wr_region;
  logic [2:0]  mb_n;
  logic        acc;
  logic        wr_link_st;
  logic        wr_link_en;
  logic        wr_fab_st;
  logic        wr_fab_en;
  logic        wr_in_mbox;
  logic        wr_out_mbox;
  logic        wr_ro_out;
  logic        ext_hit;

  assign acc         = reg_write | reg_read;
  assign wr_region   = csr_irq_pkg::region_t'(reg_addr[13:12]);
  assign mb_n        = reg_addr[4:2];
  assign wr_link_st  = reg_write & hit(reg_addr, `OFS_LINK_STATUS, `WORD_MASK);
  assign wr_link_en  = reg_write & hit(reg_addr, `OFS_LINK_ENABLE, `WORD_MASK);
  assign wr_fab_st   = reg_write & hit(reg_addr, `OFS_FAB_STATUS, `WORD_MASK);
  assign wr_fab_en   = reg_write & hit(reg_addr, `OFS_FAB_ENABLE, `WORD_MASK);
  assign wr_in_mbox  = reg_write & hit(reg_addr, `OFS_IN_MBOX, `MBOX_WIN_MASK);
  assign wr_out_mbox = reg_write & hit(reg_addr, `OFS_OUT_MBOX_FAB, `MBOX_WIN_MASK);
  assign wr_ro_out   = reg_write & hit(reg_addr, `OFS_OUT_MBOX, `MBOX_WIN_MASK);
  assign ext_hit     = (wr_region == csr_irq_pkg::REGION_XLAT) |
                       (wr_region == csr_irq_pkg::REGION_RP);

  // ========================================================================
  // Mailbox store
  mbox_if mb ();
  logic [13:0] rd_addr_r;

  assign mb.wr_en   = wr_in_mbox | wr_out_mbox;
  assign mb.wr_idx  = {wr_out_mbox, mb_n};
  assign mb.wr_data = reg_wdata;
  assign mb.wr_be   = reg_byteen;
  assign mb.rd_idx  = {~rd_addr_r[13] ? rd_addr_r[8] : ~rd_addr_r[8], rd_addr_r[4:2]};

  mbox_bank u_mbox (
    .core_clk (core_clk),
    .reset    (reset),
    .mb       (mb.store)
  );

  // ========================================================================
  // Link-bound flags and enables
  logic [7:0]  out_flags_r;
  logic [7:0]  out_flags_nxt;
  logic [7:0]  out_set;
  logic [7:0]  out_clr;
  logic [23:0] link_en_r;
  logic [31:0] link_en_nxt;
  logic [31:0] link_status;
  logic        pending;

  assign out_set = wr_out_mbox ? 8'(8'h01 << mb_n) : 8'h00;
  assign out_clr = (wr_link_st & reg_byteen[2]) ? reg_wdata[23:16] : 8'h00;
  assign out_flags_nxt = (out_flags_r & ~out_clr) | out_set;
  assign link_en_nxt = csr_irq_pkg::be_merge({8'h00, link_en_r}, reg_wdata, reg_byteen);
  assign link_status = {8'h00, out_flags_r, fab_lvl};
  assign pending = |({out_flags_r, fab_lvl} & link_en_r);

  always_ff @(posedge core_clk or posedge reset) begin
    if (reset) begin
      out_flags_r <= `LINK_FLAGS_RST;
      link_en_r   <= `LINK_EN_RST;
    end else begin
      out_flags_r <= out_flags_nxt;
      if (wr_link_en) begin
        link_en_r <= link_en_nxt[23:0];
      end
    end
  end

  // ========================================================================
  // Fabric-bound flags and enables
  logic [7:0] in_flags_r;
  logic [7:0] in_set;
  logic [7:0] in_clr;
  logic [7:0] fab_en_r;
  logic [7:0] fab_src;
  logic       fab_pend;

  assign in_set   = wr_in_mbox ? 8'(8'h01 << mb_n) : 8'h00;
  assign in_clr   = (wr_fab_st & reg_byteen[0]) ? reg_wdata[7:0] : 8'h00;
  assign fab_src  = root_s ? {4'h0, rp_intx_s} : in_flags_r;
  assign fab_pend = |(fab_src & fab_en_r);

  always_ff @(posedge core_clk or posedge reset) begin
    if (reset) begin
      in_flags_r <= `FAB_FLAGS_RST;
      fab_en_r   <= `FAB_EN_RST;
    end else begin
      in_flags_r <= (in_flags_r & ~in_clr) | in_set;
      if (wr_fab_en & reg_byteen[0]) begin
        fab_en_r <= reg_wdata[7:0];
      end
    end
  end

  // ========================================================================
  // Interrupt delivery
  csr_irq_pkg::msi_state_t msi_st_r;
  csr_irq_pkg::msi_state_t msi_st_nxt;
  logic link_irq_r;
  logic intx_r;
  logic msi_req_r;
  logic fabric_irq_r;
  logic msi_fire;

  assign msi_fire = pending & msi_s & (msi_st_r == csr_irq_pkg::MSI_IDLE);

  always_comb begin
    case (msi_st_r)
      csr_irq_pkg::MSI_IDLE: msi_st_nxt = msi_fire ? csr_irq_pkg::MSI_SENT : msi_st_r;
      csr_irq_pkg::MSI_SENT: msi_st_nxt = pending ? msi_st_r : csr_irq_pkg::MSI_IDLE;
      default:               msi_st_nxt = csr_irq_pkg::MSI_IDLE;
    endcase
  end

  always_ff @(posedge core_clk or posedge reset) begin
    if (reset) begin
      msi_st_r     <= csr_irq_pkg::MSI_IDLE;
      link_irq_r   <= 1'b0;
      intx_r       <= 1'b0;
      msi_req_r    <= 1'b0;
      fabric_irq_r <= 1'b0;
    end else begin
      msi_st_r     <= msi_st_nxt;
      link_irq_r   <= pending;
      intx_r       <= pending & ~msi_s;
      msi_req_r    <= msi_fire;
      fabric_irq_r <= fab_pend;
    end
  end

  // ========================================================================
  // External region pass-through and read pipeline
  logic        ext_wr_r;
  logic        ext_rd_r;
  logic [1:0]  ext_region_r;
  logic [11:0] ext_addr_r;
  logic [31:0] ext_wdata_r;
  logic [3:0]  ext_be_r;
  logic        rd_pend_r;
  logic [31:0] rdata_r;
  logic        rdvalid_r;
  logic [31:0] rd_mux;
  logic        rd_mbox;

  assign rd_mbox = hit(rd_addr_r, `OFS_IN_MBOX_FAB, `MBOX_WIN_MASK) |
                   hit(rd_addr_r, `OFS_OUT_MBOX_FAB, `MBOX_WIN_MASK) |
                   hit(rd_addr_r, `OFS_IN_MBOX, `MBOX_WIN_MASK) |
                   hit(rd_addr_r, `OFS_OUT_MBOX, `MBOX_WIN_MASK);
  assign rd_mux =
    ext_rd_r ? ext_rdata :
    rd_mbox ? mb.rd_data :
    hit(rd_addr_r, `OFS_LINK_STATUS, `WORD_MASK) ? link_status :
    hit(rd_addr_r, `OFS_LINK_ENABLE, `WORD_MASK) ? {8'h00, link_en_r} :
    hit(rd_addr_r, `OFS_FAB_VECTOR, `WORD_MASK) ? {27'h0, first_set(fab_lvl)} :
    hit(rd_addr_r, `OFS_FAB_STATUS, `WORD_MASK) ? {24'h0, fab_src} :
    hit(rd_addr_r, `OFS_FAB_ENABLE, `WORD_MASK) ? {24'h0, fab_en_r} :
    32'h00000000;

  always_ff @(posedge core_clk or posedge reset) begin
    if (reset) begin
      ext_wr_r     <= 1'b0;
      ext_rd_r     <= 1'b0;
      ext_region_r <= 2'h0;
      ext_addr_r   <= 12'h000;
      ext_wdata_r  <= 32'h00000000;
      ext_be_r     <= 4'h0;
      rd_pend_r    <= 1'b0;
      rd_addr_r    <= 14'h0000;
      rdata_r      <= 32'h00000000;
      rdvalid_r    <= 1'b0;
    end else begin
      ext_wr_r     <= reg_write & ext_hit;
      ext_rd_r     <= reg_read & ext_hit;
      ext_region_r <= {reg_addr[13:12] == 2'h2, reg_addr[13:12] == 2'h1};
      ext_addr_r   <= reg_addr[11:0];
      ext_wdata_r  <= reg_wdata;
      ext_be_r     <= reg_byteen;
      rd_pend_r    <= reg_read;
      rd_addr_r    <= acc ? reg_addr : rd_addr_r;
      rdata_r      <= rd_pend_r ? rd_mux : rdata_r;
      rdvalid_r    <= rd_pend_r;
    end
  end

  // ========================================================================
  // Outputs
  assign reg_rdata   = rdata_r;
  assign reg_rdvalid = rdvalid_r;
  assign ext_wr      = ext_wr_r;
  assign ext_rd      = ext_rd_r;
  assign ext_region  = ext_region_r;
  assign ext_addr    = ext_addr_r;
  assign ext_wdata   = ext_wdata_r;
  assign ext_byteen  = ext_be_r;
  assign link_irq    = link_irq_r;
  assign intx_assert = intx_r;
  assign msi_req     = msi_req_r;
  assign fabric_irq  = fabric_irq_r;

  // ========================================================================
  // Assertions
  default clocking cb @(posedge core_clk);
  endclocking
  default disable iff (reset);

  AST_OUT_SET: assert property (
    wr_out_mbox |=> out_flags_r[$past(mb_n)])
    else $error("outbound write did not set flag");
  AST_W1C: assert property (
    (wr_link_st && reg_byteen[2] && reg_wdata[16] && !out_set[0]) |=> !out_flags_r[0])
    else $error("write one did not clear flag");
  AST_LIVE: assert property (
    $stable(fabric_irq_in)[*3] |-> link_status[15:0] == fabric_irq_in)
    else $error("live level field mismatch");
  AST_IRQ_ON: assert property (
    (out_flags_r[0] && link_en_r[16]) |=> link_irq_r)
    else $error("enabled flag gave no interrupt");
  AST_IRQ_OFF: assert property (
    (link_en_r == 24'h000000) |=> !link_irq_r)
    else $error("interrupt without enabled source");
  AST_INTX: assert property (
    intx_r |-> link_irq_r && !$past(msi_s))
    else $error("legacy interrupt in wrong mode");
  AST_MSI_PULSE: assert property (
    msi_req_r |=> !msi_req_r)
    else $error("message request longer than a cycle");
  AST_RD_LAT: assert property (
    reg_read |-> ##2 reg_rdvalid)
    else $error("read answer not two cycles later");
  AST_IN_SET: assert property (
    wr_in_mbox |=> in_flags_r[$past(mb_n)])
    else $error("inbound write did not set flag");
  AST_RSVD: assert property (
    reg_rdvalid && $past(rd_addr_r) == `OFS_LINK_STATUS |-> reg_rdata[31:24] == 8'h00)
    else $error("reserved status bits not zero");
  AST_RO_OUT: assert property (
    wr_ro_out |-> !mb.wr_en)
    else $error("link side wrote outbound mailbox");
  AST_EXT: assert property (
    (reg_write && reg_addr[13:12] == 2'h1) |=> ext_wr && ext_region == 2'b01)
    else $error("translation write not forwarded");

  COV_OUT_IRQ: cover property (wr_out_mbox ##[1:4] link_irq_r);
  COV_MSI: cover property (msi_req_r);
  COV_EXT_RD: cover property (ext_rd_r ##1 reg_rdvalid);
  COV_FAB_IRQ: cover property (wr_in_mbox ##[1:4] fabric_irq_r);
endmodule : pcie_bridge_csr_irq

// file: verification/ext_region_model.sv
/*
  Model of the translation-table and root-port request store behind the
  forwarded port. Assumes read data is sampled in the cycle ext_rd is high.
*/
`timescale 1ns/1ps
module ext_region_model (
  input  wire logic        core_clk,
  input  wire logic        reset,
  input  wire logic        ext_wr,
  input  wire logic        ext_rd,
  input  wire logic [1:0]  ext_region,
  input  wire logic [11:0] ext_addr,
  input  wire logic [31:0] ext_wdata,
  input  wire logic [3:0]  ext_byteen,
  output logic [31:0]      ext_rdata,
  output logic [13:0]      last_waddr,
  output logic [31:0]      last_wdata,
  output logic [3:0]       last_be
);
  logic [31:0] idle_r;
  // ==========================================================================
  // Read answer tied to region and offset, alternating negated pattern when idle
  assign ext_rdata = ext_rd ? {8'hE0, 6'h00, ext_region, 4'h0, ext_addr} : idle_r;
  always_ff @(posedge core_clk or posedge reset) begin
    if (reset) begin
      idle_r     <= 32'h5A5A5A5A;
      last_waddr <= 14'h0000;
      last_wdata <= 32'h00000000;
      last_be    <= 4'h0;
    end else begin
      idle_r <= ~idle_r + 32'h00000001;
      if (ext_wr) begin
        last_waddr <= {ext_region, ext_addr};
        last_wdata <= ext_wdata;
        last_be    <= ext_byteen;
      end
    end
  end
endmodule : ext_region_model

// file: verification/pcie_bridge_csr_irq_tb.sv
/*
  Self-checking bench of the bridge register slave: register port tasks,
  mailbox, interrupt and forwarding sequences. Assumes the region model.
*/
`timescale 1ns/1ps
`define CHK(nm, ex, got) begin tests_run++; if ((got) !== (ex)) begin err_total++; \
  $display("CHECK FAILED %s exp %h got %h", nm, ex, got); end end
module pcie_bridge_csr_irq_tb;
  logic        core_clk, reset, reg_write, reg_read, reg_rdvalid, msi_mode, root_port_mode;
  logic        ext_wr, ext_rd, link_irq, intx_assert, msi_req, fabric_irq;
  logic [13:0] reg_addr, last_waddr;
  logic [31:0] reg_wdata, reg_rdata, ext_rdata, ext_wdata, last_wdata, d;
  logic [3:0]  reg_byteen, rp_intx_in, ext_byteen, last_be;
  logic [15:0] fabric_irq_in;
  logic [1:0]  ext_region;
  logic [11:0] ext_addr;
  int          err_total, tests_run, msi_cnt, m0;

  pcie_bridge_csr_irq pcie_bridge_csr_irq_i (.core_clk(core_clk), .reset(reset),
    .reg_addr(reg_addr), .reg_write(reg_write), .reg_read(reg_read),
    .reg_wdata(reg_wdata), .reg_byteen(reg_byteen), .reg_rdata(reg_rdata),
    .reg_rdvalid(reg_rdvalid), .fabric_irq_in(fabric_irq_in), .msi_mode(msi_mode),
    .root_port_mode(root_port_mode), .rp_intx_in(rp_intx_in), .ext_wr(ext_wr),
    .ext_rd(ext_rd), .ext_region(ext_region), .ext_addr(ext_addr),
    .ext_wdata(ext_wdata), .ext_byteen(ext_byteen), .ext_rdata(ext_rdata),
    .link_irq(link_irq), .intx_assert(intx_assert), .msi_req(msi_req),
    .fabric_irq(fabric_irq));
  ext_region_model ext_region_model_i (.core_clk(core_clk), .reset(reset),
    .ext_wr(ext_wr), .ext_rd(ext_rd), .ext_region(ext_region), .ext_addr(ext_addr),
    .ext_wdata(ext_wdata), .ext_byteen(ext_byteen), .ext_rdata(ext_rdata),
    .last_waddr(last_waddr), .last_wdata(last_wdata), .last_be(last_be));

  // ==========================================================================
  // Clock, pulse counter, watchdog
  initial begin
    core_clk = 1'b0;
    forever #4 core_clk = ~core_clk;
  end
  always @(posedge core_clk) if (msi_req === 1'b1) msi_cnt++;
  initial begin
    repeat (20000) @(posedge core_clk);
    err_total++;
    test_done();
  end

  // ==========================================================================
  // Register port tasks
  task automatic wr(input logic [13:0] a, input logic [31:0] v, input logic [3:0] be = 4'hF);
    @(posedge core_clk);
    reg_write  <= 1'b1;
    reg_addr   <= a;
    reg_wdata  <= v;
    reg_byteen <= be;
    @(posedge core_clk);
    reg_write  <= 1'b0;
  endtask : wr
  task automatic rd(input logic [13:0] a, output logic [31:0] v);
    int n;
    @(posedge core_clk);
    reg_read <= 1'b1;
    reg_addr <= a;
    @(posedge core_clk);
    reg_read <= 1'b0;
    n = 0;
    do begin
      @(posedge core_clk);
      #1;
      n++;
    end while (reg_rdvalid !== 1'b1 && n < 4);
    `CHK("rdvalid", 1'b1, reg_rdvalid)
    `CHK("rd_latency", 1, n)
    v = reg_rdata;
  endtask : rd
  task automatic rc(input logic [13:0] a, input logic [31:0] e);
    logic [31:0] v;
    rd(a, v);
    `CHK("rdata", e, v)
  endtask : rc
  task automatic settle;
    repeat (3) @(posedge core_clk);
    #1;
  endtask : settle
  task automatic tend(input string nm);
    $display("test %s done, mismatches so far %0d", nm, err_total);
  endtask : tend
  task automatic test_done;
    $display("checks %0d mismatches %0d", tests_run, err_total);
    if (err_total == 0 && tests_run > 0) $display("SIMULATION PASSED");
    else $display("SIMULATION FAILED");
    $finish;
  endtask : test_done

  // ==========================================================================
  // Tests
  initial begin
    {reg_write, reg_read, msi_mode, root_port_mode} = 4'h0;
    {reg_addr, reg_wdata, reg_byteen, rp_intx_in, fabric_irq_in} = '0;
    {err_total, tests_run, msi_cnt} = '0;
    reset = 1'b1;
    repeat (2) @(posedge core_clk);
    reset <= 1'b0;
    rc(14'h0040, 32'h00000000);
    rc(14'h0050, 32'h00000000);
    rc(14'h0060, 32'h00000010);
    tend("reset_map");
    for (int i = 0; i < 8; i++) wr(14'h3A00 + 14'(4 * i), 32'hA5000000 + i);
    for (int i = 0; i < 8; i++) rc(14'h0900 + 14'(4 * i), 32'hA5000000 + i);
    wr(14'h0904, 32'h00000000);
    rc(14'h0904, 32'hA5000001);
    rc(14'h0040, 32'h00FF0000);
    `CHK("link_irq", 1'b0, link_irq)
    wr(14'h0050, 32'hFFFFFFFF);
    rc(14'h0050, 32'h00FFFFFF);
    `CHK("link_irq", 1'b1, link_irq)
    `CHK("intx", 1'b1, intx_assert)
    wr(14'h0040, 32'hFF010000);
    wr(14'h0040, 32'h00000000);
    rc(14'h0040, 32'h00FE0000);
    `CHK("link_irq", 1'b1, link_irq)
    wr(14'h0040, 32'h00FE0000, 4'h4);
    settle;
    `CHK("link_irq", 1'b0, link_irq)
    tend("outbound");
    wr(14'h0050, 32'h00FF0000);
    @(posedge core_clk);
    fabric_irq_in <= 16'h8004;
    settle;
    rc(14'h0040, 32'h00008004);
    rc(14'h0060, 32'h00000002);
    `CHK("link_irq", 1'b0, link_irq)
    wr(14'h0050, 32'h00000004, 4'h1);
    rc(14'h0050, 32'h00FF0004);
    settle;
    `CHK("link_irq", 1'b1, link_irq)
    @(posedge core_clk);
    fabric_irq_in <= 16'h0000;
    settle;
    `CHK("link_irq", 1'b0, link_irq)
    tend("fabric_levels");
    @(posedge core_clk);
    msi_mode <= 1'b1;
    settle;
    m0 = msi_cnt;
    wr(14'h3A08, 32'h00000001);
    wr(14'h3A0C, 32'h00000002);
    settle;
    `CHK("msi_count", m0 + 1, msi_cnt)
    `CHK("intx", 1'b0, intx_assert)
    `CHK("link_irq", 1'b1, link_irq)
    wr(14'h0040, 32'h000C0000);
    settle;
    wr(14'h3A08, 32'h00000003);
    settle;
    `CHK("msi_count", m0 + 2, msi_cnt)
    wr(14'h0040, 32'h00040000);
    settle;
    `CHK("link_irq", 1'b0, link_irq)
    @(posedge core_clk);
    msi_mode <= 1'b0;
    tend("msi");
    wr(14'h0804, 32'h12345678);
    rc(14'h3B04, 32'h12345678);
    rc(14'h3060, 32'h00000002);
    `CHK("fabric_irq", 1'b0, fabric_irq)
    wr(14'h3070, 32'h00000002);
    settle;
    `CHK("fabric_irq", 1'b1, fabric_irq)
    wr(14'h3060, 32'h00000002, 4'h1);
    settle;
    `CHK("fabric_irq", 1'b0, fabric_irq)
    @(posedge core_clk);
    root_port_mode <= 1'b1;
    rp_intx_in     <= 4'h5;
    settle;
    rc(14'h3060, 32'h00000005);
    @(posedge core_clk);
    root_port_mode <= 1'b0;
    tend("inbound");
    rc(14'h1008, 32'hE0010008);
    rc(14'h2FFC, 32'hE0020FFC);
    wr(14'h2004, 32'hCAFE0001, 4'h6);
    settle;
    `CHK("fwd_addr", 14'h2004, last_waddr)
    `CHK("fwd_data", 32'hCAFE0001, last_wdata)
    `CHK("fwd_be", 4'h6, last_be)
    wr(14'h0100, 32'hFFFFFFFF);
    rd(14'h0100, d);
    rc(14'h0050, 32'h00FF0004);
    tend("forward_undef");
    test_done();
  end
endmodule : pcie_bridge_csr_irq_tb
